// *** core/rdlc_pkg.sv ***
// shared constants and types for the redistributor control block
package rdlc_pkg;
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [15:0] OFF_CTRL = 16'h0000;
	localparam logic [15:0] OFF_PARTID = 16'h0014;
	localparam logic [15:0] OFF_FCTL = 16'h0020;
	localparam logic [15:0] OFF_PWR = 16'h0024;
	localparam logic [15:0] OFF_VIEWR = 16'h0028;
	localparam logic [15:0] OFF_PROPB_LO = 16'h0070;
	localparam logic [15:0] OFF_PROPB_HI = 16'h0074;
	localparam logic [15:0] OFF_PENDB_LO = 16'h0078;
	localparam logic [15:0] OFF_PENDB_HI = 16'h007C;
	localparam logic [15:0] OFF_INV1_LO = 16'h00A0;
	localparam logic [15:0] OFF_INV1_HI = 16'h00A4;
	localparam logic [15:0] OFF_INVALL_LO = 16'h00B0;
	localparam logic [15:0] OFF_INVALL_HI = 16'h00B4;
	localparam logic [15:0] OFF_SYNC = 16'h00C0;
	localparam logic [15:0] OFF_AFF = 16'h0100;
	localparam logic [15:0] OFF_IRQ_STAT = 16'h0200;
	localparam logic [15:0] OFF_IRQ_EN = 16'h0204;
	localparam logic [15:0] OFF_IRQ_CLR = 16'h0208;

	// control register fields
	localparam int BIT_UPSTREAM = 31;
	localparam int BIT_DPG_HI = 26;
	localparam int BIT_DPG_LO = 24;
	localparam int BIT_WR_PEND = 3;
	localparam int BIT_IF = 2;
	localparam int BIT_CLR_SUP = 1;
	localparam int BIT_EN = 0;

	// interrupt status fields
	localparam int IRQ_W = 3;
	localparam int IRQ_WR_DONE = 0;
	localparam int IRQ_DENIED = 1;
	localparam int IRQ_UP_DONE = 2;

	// reset values
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [2:0] CTRL_DPG_RST = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

	// view codes
	localparam logic [1:0] VIEW0 = 2'h0;
	localparam logic [1:0] VIEW2 = 2'h2;
	localparam logic [1:0] VIEW3 = 2'h3;

	// cycles a control write stays pending when nothing must be flushed
	localparam int SETTLE_CYCLES = 4;

	// write sequencer states
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_PROP, SEQ_FLUSH} rdlc_seq_e;
endpackage

// *** core/rdlc_top.sv ***
// redistributor control register, view gating and interrupt status
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rdlc_top #(
	parameter bit LPI_SUPPORT = 1'b1,
	parameter int PROP_CYCLES = rdlc_pkg::SETTLE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [rdlc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rdlc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_view,
	input wire logic [1:0] i_ctrl_view,
	input wire logic i_no_ns_grp1,
	input wire logic i_upstream_busy,
	input wire logic i_flush_done,
	input wire logic i_others_active,
	output logic [rdlc_pkg::DATA_W-1:0] o_rdata,
	output logic o_irq,
	output logic o_lpi_enable,
	output logic [2:0] o_sel_disable,
	output logic o_flush_req,
	output logic o_pend_access,
	output logic o_prop_access
);
	import rdlc_pkg::*;

	// whole register-side state
	typedef struct packed {
		logic en;
		logic [2:0] dpg;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] ien;
		logic irq;
		logic up_prev;
		logic pend_acc;
		logic prop_acc;
		logic [DATA_W-1:0] rdata;
	} rdlc_top_s;

	rdlc_top_s q; // registered state
	rdlc_top_s d; // next state

	logic ok; // access allowed in this view
	logic ctrl_wr; // permitted control write
	logic new_en; // enable value being written
	logic seq_start; // start write sequencer
	logic seq_flush_go; // enable falls, flush needed
	logic seq_busy; // write still in progress
	logic seq_done; // write finished, one cycle
	logic [IRQ_W-1:0] ev; // event set pulses
	logic [IRQ_W-1:0] clr; // software clear mask
	logic [DATA_W-1:0] ctrl_img; // control readback image

	// registers reachable in view 0 only
	function automatic logic is_view0_reg(input logic [ADDR_W-1:0] a);
		return a inside {OFF_FCTL, OFF_PWR, OFF_VIEWR, OFF_IRQ_STAT, OFF_IRQ_EN, OFF_IRQ_CLR};
	endfunction

	// registers barred in views 2 and 3
	function automatic logic is_not23_reg(input logic [ADDR_W-1:0] a);
		return a inside {OFF_PARTID, OFF_PROPB_LO, OFF_PROPB_HI, OFF_PENDB_LO,
			OFF_PENDB_HI, OFF_INV1_LO, OFF_INV1_HI, OFF_INVALL_LO,
			OFF_INVALL_HI, OFF_SYNC, OFF_AFF};
	endfunction

	// view gate for one access
	function automatic logic access_ok(input logic [ADDR_W-1:0] a,
		input logic [1:0] v, input logic [1:0] cv);
		logic r;
		r = 1'b1;
		if (a == OFF_CTRL) begin
			r = (v == cv);
		end else if (is_view0_reg(a)) begin
			r = (v == VIEW0);
		end else if (is_not23_reg(a)) begin
			r = !((v == VIEW2) || (v == VIEW3));
		end
		return r;
	endfunction

	// write sequencer owns the pending flag and the flush request
	rdlc_wrseq #(
		.PROP_CYCLES(PROP_CYCLES),
		.CNT_W(8)
	) u_seq (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_start(seq_start),
		.i_flush(seq_flush_go),
		.i_flush_done(i_flush_done),
		.o_busy(seq_busy),
		.o_flush(o_flush_req),
		.o_done(seq_done)
	);

	// next-state logic for registers, events and readback
	always_comb begin
		d = q;
		ok = access_ok(i_addr, i_view, i_ctrl_view);
		ctrl_wr = i_wr && ok && (i_addr == OFF_CTRL);
		new_en = LPI_SUPPORT && i_wdata[BIT_EN];
		seq_start = ctrl_wr;
		// only a 1 to 0 change of the enable needs a flush
		seq_flush_go = ctrl_wr && q.en && !new_en;
		// control image; reserved ranges stay zero
		ctrl_img = '0;
		ctrl_img[BIT_UPSTREAM] = i_upstream_busy;
		ctrl_img[BIT_DPG_HI:BIT_DPG_LO] = q.dpg;
		ctrl_img[BIT_WR_PEND] = seq_busy;
		ctrl_img[BIT_IF] = LPI_SUPPORT;
		ctrl_img[BIT_CLR_SUP] = 1'b1;
		ctrl_img[BIT_EN] = q.en;
		// control write
		if (ctrl_wr) begin
			d.en = new_en;
			if (!i_no_ns_grp1) begin
				d.dpg = i_wdata[BIT_DPG_HI:BIT_DPG_LO];
			end
		end
		// exclusion bits forced clear while the flag is set
		if (i_no_ns_grp1) begin
			d.dpg = '0;
		end
		// interrupt enable write
		if (i_wr && ok && (i_addr == OFF_IRQ_EN)) begin
			d.ien = i_wdata[IRQ_W-1:0];
		end
		// clear register, write-one-to-clear
		clr = '0;
		if (i_wr && ok && (i_addr == OFF_IRQ_CLR)) begin
			clr = i_wdata[IRQ_W-1:0];
		end
		// events
		ev = '0;
		ev[IRQ_WR_DONE] = seq_done;
		ev[IRQ_DENIED] = (i_rd || i_wr) && !ok;
		ev[IRQ_UP_DONE] = q.up_prev && !i_upstream_busy;
		d.up_prev = i_upstream_busy;
		// set wins over a clear in the same cycle
		d.stat = (q.stat & ~clr) | ev;
		d.irq = |(d.stat & d.ien);
		// memory access permissions
		d.pend_acc = q.en || seq_busy;
		d.prop_acc = q.en || seq_busy || i_others_active;
		// readback; denied and unmapped reads give zero
		d.rdata = '0;
		if (i_rd && ok) begin
			unique case (i_addr)
				OFF_CTRL: begin
					d.rdata = ctrl_img;
				end
				OFF_IRQ_STAT: begin
					d.rdata[IRQ_W-1:0] = q.stat;
				end
				OFF_IRQ_EN: begin
					d.rdata[IRQ_W-1:0] = q.ien;
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
			q.en <= CTRL_EN_RST;
			q.dpg <= CTRL_DPG_RST;
			q.ien <= IRQ_EN_RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign o_rdata = q.rdata;
	assign o_irq = q.irq;
	assign o_lpi_enable = q.en;
	assign o_sel_disable = q.dpg;
	assign o_pend_access = q.pend_acc;
	assign o_prop_access = q.prop_acc;

	// checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// control read strobe with the view allowing it
	logic ctrl_rd;
	assign ctrl_rd = i_ce && i_rd && (i_addr == OFF_CTRL) && (i_view == i_ctrl_view);

	upbusy_read_a: assert property (ctrl_rd |=> o_rdata[BIT_UPSTREAM] == $past(i_upstream_busy))
		else $error("upstream pending bit wrong");
	dpg_write_a: assert property (i_ce && ctrl_wr && !i_no_ns_grp1
		|=> o_sel_disable == $past(i_wdata[BIT_DPG_HI:BIT_DPG_LO]))
		else $error("exclusion bits not stored");
	no1n_zero_a: assert property (i_ce && i_no_ns_grp1 |=> o_sel_disable == 3'h0)
		else $error("exclusion bits set while flag high");
	wrpend_read_a: assert property (ctrl_rd |=> o_rdata[BIT_WR_PEND] == $past(seq_busy))
		else $error("write pending bit wrong");
	wrpend_hold_a: assert property (i_ce && ctrl_wr && !seq_flush_go
		|=> seq_busy [*4])
		else $error("write pending dropped early");
	if_bit_a: assert property (ctrl_rd |=> o_rdata[BIT_IF] == LPI_SUPPORT)
		else $error("invalidate support bit wrong");
	clrsup_one_a: assert property (ctrl_rd |=> o_rdata[BIT_CLR_SUP])
		else $error("clear enable bit not one");
	enable_write_a: assert property (i_ce && ctrl_wr
		|=> o_lpi_enable == (LPI_SUPPORT && $past(i_wdata[BIT_EN])))
		else $error("enable not stored");
	flush_start_a: assert property (i_ce && ctrl_wr && o_lpi_enable && !i_wdata[BIT_EN]
		|=> o_flush_req && seq_busy)
		else $error("no flush on disable");
	flush_hold_a: assert property (o_flush_req && !i_flush_done |=> o_flush_req)
		else $error("flush ended before done");
	pend_stop_a: assert property (i_ce && !o_lpi_enable && !seq_busy |=> !o_pend_access)
		else $error("pending table still accessed");
	prop_keep_a: assert property (i_ce && (o_lpi_enable || seq_busy || i_others_active)
		|=> o_prop_access)
		else $error("property table access dropped");
	ctrl_view_a: assert property (i_ce && i_wr && (i_addr == OFF_CTRL)
		&& (i_view != i_ctrl_view) |=> $stable(o_lpi_enable) && $stable(o_sel_disable))
		else $error("control written from wrong view");
	view_gate_a: assert property (i_ce && i_rd && is_not23_reg(i_addr)
		&& (i_view == VIEW2 || i_view == VIEW3) |=> o_rdata == '0 && q.stat[IRQ_DENIED])
		else $error("barred view not refused");
	rsvd_zero_a: assert property (ctrl_rd |=> o_rdata[30:27] == 4'h0 && o_rdata[23:4] == 20'h0)
		else $error("reserved bits not zero");
	set_wins_a: assert property (i_ce && ev[IRQ_DENIED] && clr[IRQ_DENIED]
		|=> q.stat[IRQ_DENIED])
		else $error("event lost to clear");

	// read data stand one cycle, zero otherwise
	rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == '0)
		else $error("read data not idle");
	// any refused read gives zero and flags the refusal
	denied_zero_a: assert property (i_ce && i_rd && !ok
		|=> o_rdata == '0 && q.stat[IRQ_DENIED])
		else $error("refused read not zero");
	// view 0 only registers ignore writes from other views
	view0_gate_a: assert property (i_ce && i_wr && (i_addr == OFF_IRQ_EN)
		&& (i_view != VIEW0) |=> $stable(q.ien))
		else $error("view 0 register written elsewhere");
	// enable holds between control writes
	en_hold_a: assert property (i_ce && !ctrl_wr |=> $stable(o_lpi_enable))
		else $error("enable changed without write");
	// exclusion bits hold between control writes while the flag is clear
	dpg_hold_a: assert property (i_ce && !ctrl_wr && !i_no_ns_grp1
		|=> $stable(o_sel_disable))
		else $error("exclusion bits changed without write");
	// a flush starts only on a falling enable
	flush_cause_a: assert property (i_ce && !o_flush_req && !seq_flush_go
		|=> !o_flush_req)
		else $error("flush without disable");
	// the pending bit covers the whole flush
	flush_busy_a: assert property (o_flush_req |-> seq_busy)
		else $error("flush outside write pending");
	// pending table stays reachable while enabled
	pend_keep_a: assert property (i_ce && o_lpi_enable |=> o_pend_access)
		else $error("pending table access lost");
	// property table released once everything is quiet
	prop_stop_a: assert property (i_ce && !o_lpi_enable && !seq_busy
		&& !i_others_active |=> !o_prop_access)
		else $error("property table still accessed");
	// enable cannot be set without message support
	en_support_a: assert property (!LPI_SUPPORT |-> !o_lpi_enable)
		else $error("enable set without support");
	// finished write raises its status bit
	done_stat_a: assert property (i_ce && seq_done |=> q.stat[IRQ_WR_DONE])
		else $error("write done not flagged");
	// upstream drain raises its status bit
	upfall_stat_a: assert property (i_ce && ev[IRQ_UP_DONE] |=> q.stat[IRQ_UP_DONE])
		else $error("upstream drain not flagged");
	// clear without a new event empties the bit
	clr_works_a: assert property (i_ce && clr[IRQ_DENIED] && !ev[IRQ_DENIED]
		|=> !q.stat[IRQ_DENIED])
		else $error("status bit not cleared");
	// interrupt line follows enabled status
	irq_level_a: assert property (i_ce |=> o_irq == |(q.stat & q.ien))
		else $error("interrupt level wrong");

	flush_seen_c: cover property (o_flush_req ##[1:20] !seq_busy);
	denied_seen_c: cover property (i_ce && ev[IRQ_DENIED]);
	irq_seen_c: cover property (o_irq ##1 !o_irq);
	settle_seen_c: cover property (seq_busy ##1 !seq_busy && !o_lpi_enable);
	slow_flush_c: cover property (o_flush_req [*8]);
endmodule

// *** core/rdlc_wrseq.sv ***
// control write sequencer: pending flag, flush request, done pulse
`timescale 1ns/1ps
module rdlc_wrseq #(
	parameter int PROP_CYCLES = rdlc_pkg::SETTLE_CYCLES,
	parameter int CNT_W = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_flush,
	input wire logic i_flush_done,
	output logic o_busy,
	output logic o_flush,
	output logic o_done
);
	import rdlc_pkg::*;

	// whole sequencer state
	typedef struct packed {
		rdlc_seq_e st;
		logic [CNT_W-1:0] cnt;
		logic busy;
		logic flush;
		logic done;
	} rdlc_seq_s;

	rdlc_seq_s q; // registered state
	rdlc_seq_s d; // next state

	// next-state logic; a flush request always wins over plain settling
	always_comb begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			SEQ_IDLE: begin
				if (i_start && i_flush) begin
					d.st = SEQ_FLUSH;
				end else if (i_start) begin
					d.st = SEQ_PROP;
					d.cnt = CNT_W'(PROP_CYCLES - 1);
				end
			end
			SEQ_PROP: begin
				if (i_start && i_flush) begin
					d.st = SEQ_FLUSH;
				end else if (i_start) begin
					// new write restarts the settle time
					d.cnt = CNT_W'(PROP_CYCLES - 1);
				end else if (q.cnt == '0) begin
					d.st = SEQ_IDLE;
					d.done = 1'b1;
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			SEQ_FLUSH: begin
				// held until the core side reports the flush complete
				if (i_flush_done) begin
					d.st = SEQ_IDLE;
					d.done = 1'b1;
				end
			end
			// unused state code falls back to idle
			default: begin
				d.st = SEQ_IDLE;
			end
		endcase
		d.busy = (d.st != SEQ_IDLE);
		d.flush = (d.st == SEQ_FLUSH);
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_busy = q.busy;
	assign o_flush = q.flush;
	assign o_done = q.done;
endmodule

// *** sim/rdlc_far_model.sv ***
// behavioural core-side model that answers flush requests
`timescale 1ns/1ps
module rdlc_far_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_flush_req,
	input wire logic i_slow,
	output logic o_flush_done
);
	logic [3:0] wait_q; // cycles spent in the current flush
	// count cycles of the request, then report done for one cycle
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wait_q <= 4'h0;
			o_flush_done <= 1'b0;
		end else if (i_flush_req && !o_flush_done) begin
			wait_q <= wait_q + 4'h1;
			o_flush_done <= (wait_q == (i_slow ? 4'hB : 4'h0));
		end else begin
			wait_q <= 4'h0;
			o_flush_done <= 1'b0;
		end
	end
endmodule

// *** sim/test_rdlc_top.sv ***
// self-checking bench for the redistributor control block
`timescale 1ns/1ps
module test_rdlc_top;
	import rdlc_pkg::*;
	logic i_clock, i_rst, i_wr, i_rd, i_no_ns_grp1, i_upstream_busy, i_others_active, slow;
	logic o_irq, o_lpi_enable, o_flush_req, o_pend_access, o_prop_access, flush_done;
	logic [15:0] i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	logic [1:0] i_view, i_ctrl_view;
	logic [2:0] o_sel_disable;
	int err_count, checks, cyc, i, k;
	// forbidden places and the view that is refused there
	logic [15:0] bad_a [9] = '{16'h0014, 16'h0070, 16'h007C, 16'h00A0, 16'h00B4,
		16'h0100, 16'h0020, 16'h0024, 16'h0028};
	logic [1:0] bad_v [9] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
	rdlc_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_view(i_view),
		.i_ctrl_view(i_ctrl_view), .i_no_ns_grp1(i_no_ns_grp1),
		.i_upstream_busy(i_upstream_busy), .i_flush_done(flush_done),
		.i_others_active(i_others_active), .o_rdata(o_rdata), .o_irq(o_irq),
		.o_lpi_enable(o_lpi_enable), .o_sel_disable(o_sel_disable),
		.o_flush_req(o_flush_req), .o_pend_access(o_pend_access),
		.o_prop_access(o_prop_access));
	rdlc_far_model far (.i_clock(i_clock), .i_rst(i_rst), .i_flush_req(o_flush_req),
		.i_slow(slow), .o_flush_done(flush_done));
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task wr(input logic [15:0] a, input logic [31:0] v, input logic [1:0] vw);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		i_view <= vw;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	// one-cycle read strobe, data taken in the next cycle
	task rd(input logic [15:0] a, input logic [1:0] vw);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		i_view <= vw;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// verdict and end of run
	task complete_run;
		$display("mismatches %0d compares %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// clock source
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	// hang guard
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			complete_run();
		end
	end
	// main sequence
	initial begin
		{i_wr, i_rd, i_no_ns_grp1, i_upstream_busy, i_others_active, slow} = '0;
		i_addr = '0;
		i_wdata = '0;
		i_view = VIEW0;
		i_ctrl_view = VIEW0;
		i_rst = 1'b1;
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(OFF_CTRL, VIEW0); chk(d, 32'h6);
		wr(OFF_CTRL, 32'hFFFFFFFF, VIEW0);
		rd(OFF_CTRL, VIEW0); chk(d, 32'h0700000F);
		chk(32'(o_lpi_enable), 32'h1);
		chk(32'(o_sel_disable), 32'h7);
		repeat (8) @(posedge i_clock);
		i_upstream_busy <= 1'b1;
		rd(OFF_CTRL, VIEW0); chk(d, 32'h87000007);
		i_upstream_busy <= 1'b0;
		rd(OFF_CTRL, VIEW0); chk(d, 32'h07000007);
		i_no_ns_grp1 <= 1'b1;
		wr(OFF_CTRL, 32'h07000001, VIEW0);
		repeat (8) @(posedge i_clock);
		rd(OFF_CTRL, VIEW0); chk(d, 32'h00000007);
		chk(32'(o_sel_disable), 32'h0);
		i_no_ns_grp1 <= 1'b0;
		wr(OFF_CTRL, 32'h01000001, VIEW0);
		repeat (8) @(posedge i_clock);
		#1 chk(32'(o_sel_disable), 32'h1);
		// disable with a slow, then a prompt core
		for (k = 0; k < 2; k++) begin
			@(posedge i_clock);
			slow <= (k == 0);
			i_others_active <= 1'b1;
			wr(OFF_CTRL, 32'h01000001, VIEW0);
			repeat (8) @(posedge i_clock);
			wr(OFF_CTRL, 32'h01000000, VIEW0);
			repeat (3) @(posedge i_clock);
			#1 chk(32'(o_flush_req), 32'(k == 0));
			chk(32'(o_lpi_enable), 32'h0);
			for (i = 0; i < 40; i++) begin
				rd(OFF_CTRL, VIEW0);
				if (d[BIT_WR_PEND] === 1'b0) break;
			end
			chk(d, 32'h01000006);
			chk(32'(o_flush_req), 32'h0);
			chk(32'(o_pend_access), 32'h0);
			chk(32'(o_prop_access), 32'h1);
			i_others_active <= 1'b0;
			repeat (3) @(posedge i_clock);
			#1 chk(32'(o_prop_access), 32'h0);
		end
		// interrupt: clear, mask, raise
		wr(OFF_IRQ_CLR, 32'h7, VIEW0);
		wr(OFF_IRQ_EN, 32'h1, VIEW0);
		rd(OFF_IRQ_STAT, VIEW0); chk(d, 32'h0);
		i_ctrl_view <= 2'h1;
		rd(OFF_CTRL, VIEW0); chk(d, 32'h0);
		rd(OFF_CTRL, 2'h1); chk(d, 32'h01000006);
		chk(32'(o_irq), 32'h0);
		wr(OFF_IRQ_EN, 32'h7, VIEW0);
		rd(OFF_IRQ_STAT, VIEW0); chk(d, 32'h2);
		chk(32'(o_irq), 32'h1);
		wr(OFF_IRQ_EN, 32'h0, 2'h1);
		rd(OFF_IRQ_EN, VIEW0); chk(d, 32'h7);
		for (i = 0; i < 9; i++) begin
			wr(OFF_IRQ_CLR, 32'h7, VIEW0);
			rd(bad_a[i], bad_v[i]); chk(d, 32'h0);
			rd(OFF_IRQ_STAT, VIEW0); chk(d, 32'h2);
		end
		wr(OFF_IRQ_CLR, 32'h7, VIEW0);
		rd(OFF_PARTID, 2'h1);
		rd(16'h0300, VIEW0);
		rd(OFF_IRQ_STAT, VIEW0); chk(d, 32'h0);
		chk(32'(o_irq), 32'h0);
		complete_run();
	end
endmodule
